// >>> bench/uart_serial_port_control_tb.sv
// Self-checking bench: register accesses, frames in every mode, filtering and overrun.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module uart_serial_port_control_tb;
	import uspc_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, baud16_tick = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, c, r;
	logic rxd_out, rxd_oe_n, txd, line, rxd_in;
	logic [10:0] got;
	int mismatches = 0, num_checks = 0;
	logic [7:0] cc [4] = '{8'hf0, 8'hf0, 8'h70, 8'h40};
	logic [3:0] b9 = 4'ha, exri = 4'h2;
	logic double_rate = 1'b1;
	assign rxd_in = rxd_oe_n ? line : rxd_out;
	uspc_top dut (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.double_rate, .baud16_tick, .rxd_in, .rxd_out, .rxd_oe_n, .txd);
	uspc_partner #(.P(32)) p (.ref_clk, .txd, .dpin(rxd_in), .line);
	initial forever #20 ref_clk = ~ref_clk;
	// A tick every second cycle gives 32-cycle bits in modes 1 and 3; mode 2 ignores it and uses the fixed divider.
	initial forever begin
		@(posedge ref_clk);
		#1 baud16_tick = ~baud16_tick;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
		@(posedge ref_clk);
		#1 sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1 {sfr_rd, sfr_addr} = {1'b1, a};
		@(posedge ref_clk);
		#1 sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		rd(USPC_ADDR_CTRL, c);
		`CHK(c, USPC_CTRL_RESET)
		rd(8'h97, c);
		`CHK(c, 8'h00)
		wr(USPC_ADDR_CTRL, 8'h00);
		fork
			wr(USPC_ADDR_BUF, 8'h96);
			p.m0_grab(got);
		join
		`CHK(got, 11'h096)
		repeat (24) @(posedge ref_clk);
		rd(USPC_ADDR_CTRL, c);
		`CHK(c, 8'h02)
		// Shift mode receive starts as soon as the enable is set with the flag clear.
		wr(USPC_ADDR_CTRL, 8'h10);
		p.m0_send(8'h3c);
		repeat (8) @(posedge ref_clk);
		rd(USPC_ADDR_CTRL, c);
		`CHK(c, 8'h11)
		rd(USPC_ADDR_BUF, r);
		`CHK(r, 8'h3c)
		for (int m = 1; m < 4; m++) begin
			int nb;
			logic [7:0] d;
			nb = (m == 1) ? 8 : 9;
			d = 8'ha5 ^ 8'(m);
			wr(USPC_ADDR_CTRL, {2'(m), 6'h08});
			fork
				wr(USPC_ADDR_BUF, d);
				p.grab(nb, got);
			join
			`CHK(got, (m == 1) ? {2'b01, d, 1'b0} : {2'b11, d, 1'b0})
			repeat (100) @(posedge ref_clk);
			rd(USPC_ADDR_CTRL, c);
			`CHK(c, {2'(m), 6'h0a})
			wr(USPC_ADDR_CTRL, {2'(m), 6'h10});
			p.send({1'b0, ~d}, nb, 1'b1);
			repeat (8) @(posedge ref_clk);
			rd(USPC_ADDR_CTRL, c);
			`CHK(c, {2'(m), 3'b010, m == 1, 2'b01})
			rd(USPC_ADDR_BUF, r);
			`CHK(r, ~d)
			wr(USPC_ADDR_CTRL, 8'h00);
		end
		// Fixed rate nine-bit mode at the slow setting: 64 cycles a bit.
		double_rate = 1'b0;
		p.per = 64;
		wr(USPC_ADDR_CTRL, 8'h98);
		fork
			wr(USPC_ADDR_BUF, 8'hc3);
			p.grab(9, got);
		join
		`CHK(got, {2'b11, 8'hc3, 1'b0})
		p.send(9'h13c, 9, 1'b1);
		repeat (8) @(posedge ref_clk);
		rd(USPC_ADDR_CTRL, c);
		`CHK(c, 8'h9f)
		rd(USPC_ADDR_BUF, r);
		`CHK(r, 8'h3c)
		wr(USPC_ADDR_CTRL, 8'h00);
		double_rate = 1'b1;
		p.per = 32;
		for (int k = 0; k < 4; k++) begin
			wr(USPC_ADDR_CTRL, cc[k]);
			if (k < 2)
				p.send({b9[k], 8'h5a}, 9, 1'b1);
			else
				p.send({1'b0, 8'h5a}, 8, b9[k]);
			repeat (8) @(posedge ref_clk);
			rd(USPC_ADDR_CTRL, c);
			`CHK(c[0], exri[k])
			wr(USPC_ADDR_CTRL, 8'h00);
		end
		wr(USPC_ADDR_CTRL, 8'h50);
		p.send(9'h011, 8, 1'b1);
		p.send(9'h022, 8, 1'b1);
		repeat (8) @(posedge ref_clk);
		rd(USPC_ADDR_BUF, r);
		`CHK(r, 8'h22)
		summarize();
	end
endmodule
bind uspc_top uspc_checker chk (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
	.sfr_rdata, .rxd_out, .rxd_oe_n, .txd);

// >>> bench/uspc_checker.sv
// Port-level assertions for the serial port control block.
`timescale 1ns/1ps
module uspc_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [uspc_pkg::USPC_AW-1:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [uspc_pkg::USPC_DW-1:0] sfr_wdata,
	input wire logic [uspc_pkg::USPC_DW-1:0] sfr_rdata,
	input wire logic rxd_out,
	input wire logic rxd_oe_n,
	input wire logic txd
);
	import uspc_pkg::*;
	logic [7:0] ctl_r;
	logic [4:0] oe_cnt;
	logic [2:0] hi_cnt;
	logic [1:0] mode;
	assign mode = ctl_r[7:6];
	// Shadow of the software bits, so that checks know the mode without looking inside.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctl_r <= USPC_CTRL_RESET;
			oe_cnt <= 5'h00;
			hi_cnt <= 3'h0;
		end else begin
			if (sfr_wr && sfr_addr == USPC_ADDR_CTRL)
				ctl_r <= sfr_wdata;
			oe_cnt <= rxd_oe_n ? 5'h00 : oe_cnt + 5'h01;
			hi_cnt <= !(txd && rxd_oe_n) ? 3'h0 : (hi_cnt == 3'h4) ? hi_cnt : hi_cnt + 3'h1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_m0_clk; mode == 2'b00 && $fell(txd) |=> txd; endproperty
	a_m0_clk: assert property (p_m0_clk) else $error("shift clock low too long");
	property p_m0_only; !rxd_oe_n |-> mode == 2'b00; endproperty
	a_m0_only: assert property (p_m0_only) else $error("data pin driven outside shift mode");
	property p_async_bit; mode != 2'b00 && $fell(txd) |-> !txd [*8]; endproperty
	a_async_bit: assert property (p_async_bit) else $error("async low bit too short");
	property p_m0_start;
		sfr_wr && sfr_addr == USPC_ADDR_BUF && mode == 2'b00 && !ctl_r[4] && hi_cnt == 3'h4
		|=> !txd && !rxd_oe_n && rxd_out == $past(sfr_wdata[0]);
	endproperty
	a_m0_start: assert property (p_m0_start) else $error("shift transmit did not start");
	property p_m0_len; $rose(rxd_oe_n) |-> oe_cnt == 5'h10; endproperty
	a_m0_len: assert property (p_m0_len) else $error("shift transmit length wrong");
	property p_rd_hold; !$past(sfr_rd) |-> $stable(sfr_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
	property p_unmapped;
		sfr_rd && sfr_addr != USPC_ADDR_CTRL && sfr_addr != USPC_ADDR_BUF |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctl_back;
		sfr_rd && !sfr_wr && sfr_addr == USPC_ADDR_CTRL |=> sfr_rdata[7:3] == ctl_r[7:3];
	endproperty
	a_ctl_back: assert property (p_ctl_back) else $error("control bits read back wrong");
	c_m0_tx: cover property ($fell(rxd_oe_n));
	c_async: cover property (mode != 2'b00 && $fell(txd));
	c_unmapped: cover property (sfr_rd && sfr_addr == 8'h97);
	c_m0_rx: cover property (mode == 2'b00 && ctl_r[4] && $fell(txd));
endmodule

// >>> bench/uspc_partner.sv
// Remote serial device: sends frames on the receive line and captures transmitted ones.
`timescale 1ns/1ps
module uspc_partner #(
	parameter int P = 32
) (
	input wire logic ref_clk,
	input wire logic txd,
	input wire logic dpin,
	output logic line
);
	int per = P;
	initial line = 1'b1;
	// The stop level is a parameter of the call so that framing faults can be sent.
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		for (int i = 0; i <= nb + 1; i++) begin
			@(posedge ref_clk);
			#1 line = (i == 0) ? 1'b0 : (i > nb) ? stp : d[i-1];
			repeat (per - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		#1 line = 1'b1;
	endtask
	task automatic grab(input int nb, output logic [10:0] f);
		int k;
		f = 11'h000;
		for (k = 0; k < 4000 && txd !== 1'b0; k++)
			@(posedge ref_clk);
		if (k < 4000) begin
			repeat (per / 2) @(posedge ref_clk);
			for (int i = 0; i <= nb + 1; i++) begin
				f[i] = txd;
				repeat (per) @(posedge ref_clk);
			end
		end
	endtask
	// Shift mode: the data pin is read just after the shift clock rises; f[10] flags a timeout.
	task automatic m0_grab(output logic [10:0] f);
		int k;
		f = 11'h000;
		k = 0;
		for (int i = 0; i < 8; i++) begin
			while (k < 400 && txd !== 1'b0) begin
				@(posedge ref_clk);
				#1 k++;
			end
			while (k < 400 && txd !== 1'b1) begin
				@(posedge ref_clk);
				#1 k++;
			end
			f[i] = dpin;
		end
		f[10] = (k >= 400);
	endtask
	// New data goes out while the shift clock is low and holds past the edge that samples it.
	task automatic m0_send(input logic [7:0] v);
		int k;
		k = 0;
		for (int i = 0; i < 8; i++) begin
			while (k < 400 && txd !== 1'b0) begin
				@(posedge ref_clk);
				#1 k++;
			end
			line = v[i];
			while (k < 400 && txd !== 1'b1) begin
				@(posedge ref_clk);
				#1 k++;
			end
		end
		@(posedge ref_clk);
		#1 line = 1'b1;
	endtask
endmodule

// >>> design/uspc_pkg.sv
// Shared constants and types of the serial port control block.
package uspc_pkg;
	localparam int USPC_AW = 8;
	localparam int USPC_DW = 8;
	localparam int USPC_RXW = 9;
	localparam logic [USPC_AW-1:0] USPC_ADDR_CTRL = 8'h98;
	localparam logic [USPC_AW-1:0] USPC_ADDR_BUF = 8'h99;
	localparam logic [USPC_DW-1:0] USPC_CTRL_RESET = 8'h00;
	localparam int USPC_BIT_MODE_HI = 7;
	localparam int USPC_BIT_MODE_LO = 6;
	localparam int USPC_BIT_MPE = 5;
	localparam int USPC_BIT_REN = 4;
	localparam int USPC_BIT_TB8 = 3;
	localparam int USPC_BIT_RB8 = 2;
	localparam int USPC_BIT_TI = 1;
	localparam int USPC_BIT_RI = 0;
	localparam logic [3:0] USPC_OS_LAST = 4'hf;
	localparam logic [3:0] USPC_START_MID = 4'h7;
	localparam logic [3:0] USPC_BITS_8 = 4'h8;
	localparam logic [3:0] USPC_BITS_9 = 4'h9;
	localparam logic [2:0] USPC_SHIFT_LAST = 3'h7;
	localparam logic [1:0] USPC_FIX_DIV_SLOW = 2'h3;
	localparam logic [1:0] USPC_FIX_DIV_FAST = 2'h1;

	typedef enum logic [1:0] {
		USPC_MODE_SHIFT = 2'b00,
		USPC_MODE_ASYNC8 = 2'b01,
		USPC_MODE_FIXED9 = 2'b10,
		USPC_MODE_VAR9 = 2'b11
	} uspc_mode_t;

	typedef enum logic [4:0] {
		USPC_TX_IDLE = 5'h01,
		USPC_TX_START = 5'h02,
		USPC_TX_DATA = 5'h04,
		USPC_TX_STOP = 5'h08,
		USPC_TX_SHIFT = 5'h10
	} uspc_tx_state_t;

	typedef enum logic [4:0] {
		USPC_RX_IDLE = 5'h01,
		USPC_RX_START = 5'h02,
		USPC_RX_DATA = 5'h04,
		USPC_RX_STOP = 5'h08,
		USPC_RX_SHIFT = 5'h10
	} uspc_rx_state_t;
endpackage

// >>> design/uspc_rx_buf.sv
// Two-entry receive buffer with valid and ready on both sides.
`timescale 1ns/1ps
module uspc_rx_buf #(
	parameter int W = 9
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	uspc_stream_if.sink in_s,
	uspc_stream_if.source out_s
);
	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_s.ready = (cnt_r != 2'h2);
	assign out_s.valid = (cnt_r != 2'h0);
	assign out_s.data = mem_r[rd_ptr_r];

	always_comb begin
		push = in_s.valid && in_s.ready;
		pop = out_s.valid && out_s.ready;
		mem_nxt = mem_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_ptr_r] = in_s.data;
			wr_ptr_nxt = ~wr_ptr_r;
		end
		if (pop) begin
			rd_ptr_nxt = ~rd_ptr_r;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r <= cnt_nxt;
		end
		mem_r <= mem_nxt;
	end
endmodule

// >>> design/uspc_stream_if.sv
// Valid/ready word carrier between the port logic and its receive buffer.
`timescale 1ns/1ps
interface uspc_stream_if #(parameter int W = 9);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source(output valid, output data, input ready);
	modport sink(input valid, input data, output ready);
endinterface

// >>> design/uspc_top.sv
// Serial port control: control register, buffer register, transmit and receive engines.
`timescale 1ns/1ps
module uspc_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [uspc_pkg::USPC_AW-1:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [uspc_pkg::USPC_DW-1:0] sfr_wdata,
	output logic [uspc_pkg::USPC_DW-1:0] sfr_rdata,
	input wire logic double_rate,
	input wire logic baud16_tick,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe_n,
	output logic txd
);
	import uspc_pkg::*;

	uspc_stream_if #(.W(USPC_RXW)) rx_in_if ();
	uspc_stream_if #(.W(USPC_RXW)) rx_out_if ();

	uspc_rx_buf #(.W(USPC_RXW)) u_rx_buf (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_s(rx_in_if),
		.out_s(rx_out_if)
	);

	logic [USPC_DW-1:0] ctrl_r, ctrl_nxt, rxhold_r, rxhold_nxt, rdata_r, rdata_nxt;
	logic [1:0] div_r, div_nxt;
	uspc_mode_t mode;
	logic ctrl_wr, buf_wr, buf_rd, os_tick, ti_set, rx_load, nine;

	uspc_tx_state_t tx_state_r, tx_state_nxt;
	logic [8:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_bit_r, tx_bit_nxt, tx_tick_r, tx_tick_nxt;
	logic txd_r, txd_nxt, rxo_r, rxo_nxt, oe_n_r, oe_n_nxt;

	uspc_rx_state_t rx_state_r, rx_state_nxt;
	logic [8:0] rx_sh_r, rx_sh_nxt, push_word_r, push_word_nxt;
	logic [3:0] rx_bit_r, rx_bit_nxt, rx_tick_r, rx_tick_nxt;
	logic rxd_prev_r, push_r, push_nxt, rx_sclk, accept;

	assign sfr_rdata = rdata_r;
	assign txd = txd_r;
	assign rxd_out = rxo_r;
	assign rxd_oe_n = oe_n_r;
	assign rx_in_if.valid = push_r;
	assign rx_in_if.data = push_word_r;

	// Register interface and baud divider.
	always_comb begin
		mode = uspc_mode_t'(ctrl_r[USPC_BIT_MODE_HI:USPC_BIT_MODE_LO]);
		nine = ctrl_r[USPC_BIT_MODE_HI];
		ctrl_wr = sfr_wr && (sfr_addr == USPC_ADDR_CTRL);
		buf_wr = sfr_wr && (sfr_addr == USPC_ADDR_BUF);
		buf_rd = sfr_rd && (sfr_addr == USPC_ADDR_BUF);
		// Holding off the load during a read keeps a read from seeing a half-updated byte.
		rx_out_if.ready = !buf_rd;
		rx_load = rx_out_if.valid && rx_out_if.ready;
		div_nxt = div_r - 2'h1;
		if (div_r == 2'h0) begin
			div_nxt = double_rate ? USPC_FIX_DIV_FAST : USPC_FIX_DIV_SLOW;
		end
		os_tick = (mode == USPC_MODE_FIXED9) ? (div_r == 2'h0) : baud16_tick;
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = sfr_wdata;
		end
		if (ti_set) begin
			ctrl_nxt[USPC_BIT_TI] = 1'b1;
		end
		rxhold_nxt = rxhold_r;
		if (rx_load) begin
			rxhold_nxt = rx_out_if.data[7:0];
			ctrl_nxt[USPC_BIT_RB8] = rx_out_if.data[8];
			ctrl_nxt[USPC_BIT_RI] = 1'b1;
		end
		rdata_nxt = rdata_r;
		if (sfr_rd) begin
			case (sfr_addr)
				USPC_ADDR_CTRL: rdata_nxt = ctrl_r;
				USPC_ADDR_BUF: rdata_nxt = rxhold_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_r <= USPC_CTRL_RESET;
			rxhold_r <= 8'h00;
			rdata_r <= 8'h00;
			div_r <= 2'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			rxhold_r <= rxhold_nxt;
			rdata_r <= rdata_nxt;
			div_r <= div_nxt;
		end
	end

	// Transmit engine; it also drives the shift clock pin in mode 0.
	always_comb begin
		tx_state_nxt = tx_state_r;
		tx_sh_nxt = tx_sh_r;
		tx_bit_nxt = tx_bit_r;
		tx_tick_nxt = tx_tick_r;
		txd_nxt = txd_r;
		rxo_nxt = rxo_r;
		oe_n_nxt = oe_n_r;
		ti_set = 1'b0;
		case (tx_state_r)
			USPC_TX_IDLE: begin
				txd_nxt = (mode == USPC_MODE_SHIFT) ? rx_sclk : 1'b1;
				oe_n_nxt = 1'b1;
				// A write while a character is going out, or during a mode 0 receive, is dropped.
				if (buf_wr && rx_state_r != USPC_RX_SHIFT) begin
					tx_sh_nxt = {ctrl_r[USPC_BIT_TB8], sfr_wdata};
					tx_bit_nxt = 4'h0;
					tx_tick_nxt = 4'h0;
					if (mode == USPC_MODE_SHIFT) begin
						tx_state_nxt = USPC_TX_SHIFT;
						oe_n_nxt = 1'b0;
						rxo_nxt = sfr_wdata[0];
						txd_nxt = 1'b0;
					end else begin
						tx_state_nxt = USPC_TX_START;
						txd_nxt = 1'b0;
					end
				end
			end
			USPC_TX_SHIFT: begin
				if (tx_tick_r[0] == 1'b0) begin
					txd_nxt = 1'b1;
					tx_tick_nxt = 4'h1;
				end else if (tx_bit_r[2:0] == USPC_SHIFT_LAST) begin
					tx_state_nxt = USPC_TX_IDLE;
					ti_set = 1'b1;
					oe_n_nxt = 1'b1;
				end else begin
					tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
					rxo_nxt = tx_sh_r[1];
					tx_bit_nxt = tx_bit_r + 4'h1;
					tx_tick_nxt = 4'h0;
					txd_nxt = 1'b0;
				end
			end
			USPC_TX_START, USPC_TX_DATA, USPC_TX_STOP: begin
				if (os_tick) begin
					tx_tick_nxt = tx_tick_r + 4'h1;
					if (tx_tick_r == USPC_OS_LAST) begin
						if (tx_state_r == USPC_TX_START) begin
							tx_state_nxt = USPC_TX_DATA;
							tx_bit_nxt = 4'h0;
							txd_nxt = tx_sh_r[0];
						end else if (tx_state_r == USPC_TX_STOP) begin
							tx_state_nxt = USPC_TX_IDLE;
						end else if (tx_bit_r == (nine ? USPC_BITS_9 : USPC_BITS_8) - 4'h1) begin
							tx_state_nxt = USPC_TX_STOP;
							txd_nxt = 1'b1;
							ti_set = 1'b1;
						end else begin
							tx_bit_nxt = tx_bit_r + 4'h1;
							tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
							txd_nxt = tx_sh_r[1];
						end
					end
				end
			end
			default: tx_state_nxt = USPC_TX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_state_r <= USPC_TX_IDLE;
			tx_sh_r <= 9'h000;
			tx_bit_r <= 4'h0;
			tx_tick_r <= 4'h0;
			txd_r <= 1'b1;
			rxo_r <= 1'b1;
			oe_n_r <= 1'b1;
		end else begin
			tx_state_r <= tx_state_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_tick_r <= tx_tick_nxt;
			txd_r <= txd_nxt;
			rxo_r <= rxo_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// Receive engine; finished frames wait in push_word_r until the buffer takes them.
	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_sh_nxt = rx_sh_r;
		rx_bit_nxt = rx_bit_r;
		rx_tick_nxt = rx_tick_r;
		push_nxt = push_r && !rx_in_if.ready;
		push_word_nxt = push_word_r;
		accept = 1'b0;
		case (rx_state_r)
			USPC_RX_IDLE: begin
				rx_tick_nxt = 4'h0;
				rx_bit_nxt = 4'h0;
				if (ctrl_r[USPC_BIT_REN] && !push_r) begin
					if (mode == USPC_MODE_SHIFT) begin
						// A byte still on its way to the holding register has not raised the flag yet.
						if (!ctrl_r[USPC_BIT_RI] && !rx_out_if.valid && tx_state_r == USPC_TX_IDLE
							&& !buf_wr) begin
							rx_state_nxt = USPC_RX_SHIFT;
						end
					end else if (rxd_prev_r && !rxd_in) begin
						rx_state_nxt = USPC_RX_START;
					end
				end
			end
			USPC_RX_SHIFT: begin
				if (rx_tick_r[0] == 1'b0) begin
					rx_tick_nxt = 4'h1;
				end else begin
					rx_sh_nxt = {rxd_in, rx_sh_r[8:1]};
					rx_tick_nxt = 4'h0;
					rx_bit_nxt = rx_bit_r + 4'h1;
					if (rx_bit_r[2:0] == USPC_SHIFT_LAST) begin
						rx_state_nxt = USPC_RX_IDLE;
						push_nxt = 1'b1;
						push_word_nxt = {1'b0, rxd_in, rx_sh_r[8:2]};
					end
				end
			end
			USPC_RX_START: begin
				if (os_tick) begin
					rx_tick_nxt = rx_tick_r + 4'h1;
					if (rx_tick_r == USPC_START_MID) begin
						rx_tick_nxt = 4'h0;
						// A start bit that is high again at its middle was a glitch.
						rx_state_nxt = rxd_in ? USPC_RX_IDLE : USPC_RX_DATA;
					end
				end
			end
			USPC_RX_DATA: begin
				if (os_tick) begin
					rx_tick_nxt = rx_tick_r + 4'h1;
					if (rx_tick_r == USPC_OS_LAST) begin
						rx_sh_nxt = {rxd_in, rx_sh_r[8:1]};
						rx_bit_nxt = rx_bit_r + 4'h1;
						if (rx_bit_r == (nine ? USPC_BITS_9 : USPC_BITS_8) - 4'h1) begin
							rx_state_nxt = USPC_RX_STOP;
						end
					end
				end
			end
			USPC_RX_STOP: begin
				if (os_tick) begin
					rx_tick_nxt = rx_tick_r + 4'h1;
					if (rx_tick_r == USPC_OS_LAST) begin
						rx_state_nxt = USPC_RX_IDLE;
						accept = !ctrl_r[USPC_BIT_MPE] || (nine ? rx_sh_r[8] : rxd_in);
						push_nxt = accept;
						push_word_nxt = nine ? rx_sh_r : {rxd_in, rx_sh_r[8:1]};
					end
				end
			end
			default: rx_state_nxt = USPC_RX_IDLE;
		endcase
		if (!ctrl_r[USPC_BIT_REN]) begin
			rx_state_nxt = USPC_RX_IDLE;
		end
		rx_sclk = !(rx_state_nxt == USPC_RX_SHIFT && rx_tick_nxt[0] == 1'b0);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_state_r <= USPC_RX_IDLE;
			rx_sh_r <= 9'h000;
			rx_bit_r <= 4'h0;
			rx_tick_r <= 4'h0;
			rxd_prev_r <= 1'b1;
			push_r <= 1'b0;
			push_word_r <= 9'h000;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_tick_r <= rx_tick_nxt;
			rxd_prev_r <= rxd_in;
			push_r <= push_nxt;
			push_word_r <= push_word_nxt;
		end
	end
endmodule
